// File: shared/ctt_params.svh
`ifndef CTT_PARAMS_SVH
`define CTT_PARAMS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define CTT_ADDR_T01_CTRL 8'h88
`define CTT_ADDR_T01_MODE 8'h89
`define CTT_ADDR_T0_LOW 8'h8A
`define CTT_ADDR_T1_LOW 8'h8B
`define CTT_ADDR_T0_HIGH 8'h8C
`define CTT_ADDR_T1_HIGH 8'h8D
`define CTT_ADDR_T2_CTRL 8'hC8
`define CTT_ADDR_T2_RLD_LOW 8'hCA
`define CTT_ADDR_T2_RLD_HIGH 8'hCB
`define CTT_ADDR_T2_LOW 8'hCC
`define CTT_ADDR_T2_HIGH 8'hCD

// ----------------------------------------------------------------
// timer 0/1 control register fields
// ----------------------------------------------------------------
`define CTT_T01C_OVF1 7
`define CTT_T01C_RUN1 6
`define CTT_T01C_OVF0 5
`define CTT_T01C_RUN0 4

// ----------------------------------------------------------------
// timer 0/1 mode register fields
// ----------------------------------------------------------------
`define CTT_T01M_GATE1 7
`define CTT_T01M_CSEL1 6
`define CTT_T01M_MODE1_HI 5
`define CTT_T01M_MODE1_LO 4
`define CTT_T01M_TIMER0_PIN_GATING 3
`define CTT_T01M_CSEL0 2
`define CTT_T01M_MODE0_HI 1
`define CTT_T01M_MODE0_LO 0

// ----------------------------------------------------------------
// timer 2 control register fields
// ----------------------------------------------------------------
`define CTT_T2C_OVF 7
`define CTT_T2C_EXT_FLAG 6
`define CTT_T2C_RX_BAUD 5
`define CTT_T2C_TX_BAUD 4
`define CTT_T2C_EXT_EN 3
`define CTT_T2C_RUN 2
`define CTT_T2C_CSEL 1
`define CTT_T2C_CAP_SEL 0

// ----------------------------------------------------------------
// reset values and pin count
// ----------------------------------------------------------------
`define CTT_RST_BYTE 8'h00
`define CTT_PIN_COUNT 5

`endif

// File: shared/ctt_pkg.sv
package ctt_pkg;

    // timer 0/1 mode field decode, in field order
    typedef enum logic [1:0] {
        T01_COUNT13,
        T01_COUNT16,
        T01_RELOAD8,
        T01_SPLIT
    } ctt_t01_mode_t;

    // timer 2 operating mode
    typedef enum logic [1:0] {
        T2_OFF,
        T2_RELOAD,
        T2_CAPTURE,
        T2_BAUD
    } ctt_t2_mode_t;

    // result of one count step of timer 0/1
    typedef struct packed {
        logic ovf;
        logic [7:0] hi;
        logic [7:0] lo;
    } ctt_step_t;

endpackage

// File: hw/ctt_pin_sync.sv
`timescale 1ns/100ps
module ctt_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk_i,              // core clock
    input wire logic sys_rst_i,           // async reset, active high
    input wire logic ce_i,                // clock enable
    input wire logic [WIDTH-1:0] pin_i,   // raw pin levels
    output logic [WIDTH-1:0] level_o,     // synchronised level
    output logic [WIDTH-1:0] fall_o       // one-cycle high-to-low pulse
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;

    // meta is read only by sync; edges are taken between sync and prev
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta <= '0;
            sync <= '0;
            prev <= '0;
        end else if (ce_i) begin
            meta <= pin_i;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level_o = sync;
    assign fall_o = prev & ~sync;

endmodule

// File: hw/ctt_timers.sv
`timescale 1ns/100ps
`include "ctt_params.svh"
// Overview of operation
// R1 - no prescaler, each enabled event counts once
// R2 - mode 0 counts 13 bits, low five bits
// R3 - rollover to zero sets the overflow flag
// R4 - timer 0 runs when run and gate-or-pin
// R5 - run bit 4, gates at mode bits 3/7
// R6 - setting run leaves the count registers unchanged
// R7 - mode 1 is mode 0 with 16 bits
// R8 - mode 2 reloads low byte from high byte
// R9 - timer 1 in mode 3 holds its count
// R10 - timer 0 mode 3 low byte uses timer 0 controls
// R11 - timer 0 mode 3 high byte uses timer 1 controls
// R12 - timer 1 stays usable via its mode 3
// R13 - timer 2 mode from run, baud, capture bits
// R14 - timer 2 auto-reload from reload registers on rollover
// R15 - trigger fall reloads and sets external flag
// R16 - capture mode free-runs, overflow sets flag bit 7
// R17 - trigger fall captures count, sets external flag
// R18 - baud mode never sets timer 2 overflow flag
// R19 - baud mode trigger still sets external flag
// R20 - counter select picks count pin or core clock
// R21 - baud select forces reload, ignores capture select
// R22 - pins synchronised, falling edge from sampled levels
module ctt_timers
    import ctt_pkg::*;
(
    input wire logic mclk_i,              // 20 MHz core clock
    input wire logic sys_rst_i,           // async reset, active high
    input wire logic ce_i,                // clock enable, freezes all state when low
    input wire logic [7:0] sfr_addr_i,    // register address
    input wire logic sfr_wr_i,            // register write strobe
    input wire logic [7:0] sfr_wdata_i,   // register write data
    output logic [7:0] sfr_rdata_o,       // register read data, one cycle after address
    input wire logic ext_int_a_pin_i,     // timer 0 gate pin
    input wire logic ext_int_b_pin_i,     // timer 1 gate pin
    input wire logic timer0_count_pin_i,  // timer 0 count input
    input wire logic timer1_count_pin_i,  // timer 1 count input
    input wire logic timer2_count_pin_i,  // timer 2 count input
    input wire logic timer2_trigger_pin_i, // timer 2 external trigger
    output logic timer1_overflow_o,       // timer 1 overflow pulse for baud use
    output logic timer2_overflow_o,       // timer 2 rollover pulse for baud use
    output logic timer0_irq_o,            // timer 0 overflow flag level
    output logic timer1_irq_o,            // timer 1 overflow flag level
    output logic timer2_irq_o             // timer 2 overflow or external flag level
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] timer01_control_reg;
    logic [7:0] timer01_mode_reg;
    logic [7:0] timer2_control_reg;
    logic [7:0] timer0_count_low;
    logic [7:0] timer0_count_high;
    logic [7:0] timer1_count_low;
    logic [7:0] timer1_count_high;
    logic [7:0] timer2_count_low;
    logic [7:0] timer2_count_high;
    logic [7:0] timer2_reload_low;
    logic [7:0] timer2_reload_high;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [`CTT_PIN_COUNT-1:0] pin_raw;
    logic [`CTT_PIN_COUNT-1:0] pin_level;
    logic [`CTT_PIN_COUNT-1:0] pin_fall;

    assign pin_raw = {timer2_trigger_pin_i, timer2_count_pin_i, timer1_count_pin_i,
                      timer0_count_pin_i, ext_int_a_pin_i};

    ctt_pin_sync #(
        .WIDTH(`CTT_PIN_COUNT)
    ) u_pin_sync (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .pin_i(pin_raw),
        .level_o(pin_level),
        .fall_o(pin_fall)
    );                                                   // R22

    // gate pin b only needs a level, so it gets its own two stages
    logic int_b_meta;
    logic int_b_level;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            int_b_meta <= 1'b0;
            int_b_level <= 1'b0;
        end else if (ce_i) begin
            int_b_meta <= ext_int_b_pin_i;
            int_b_level <= int_b_meta;                   // R22
        end
    end

    wire int_a_level = pin_level[0];
    wire t0_pin_fall = pin_fall[1];
    wire t1_pin_fall = pin_fall[2];
    wire t2_pin_fall = pin_fall[3];
    wire t2_trig_fall = pin_fall[4];

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    wire wr = sfr_wr_i & ce_i;
    wire wr_t01c = wr && (sfr_addr_i == `CTT_ADDR_T01_CTRL);
    wire wr_t01m = wr && (sfr_addr_i == `CTT_ADDR_T01_MODE);
    wire wr_t2c = wr && (sfr_addr_i == `CTT_ADDR_T2_CTRL);
    wire wr_t0l = wr && (sfr_addr_i == `CTT_ADDR_T0_LOW);
    wire wr_t0h = wr && (sfr_addr_i == `CTT_ADDR_T0_HIGH);
    wire wr_t1l = wr && (sfr_addr_i == `CTT_ADDR_T1_LOW);
    wire wr_t1h = wr && (sfr_addr_i == `CTT_ADDR_T1_HIGH);
    wire wr_t2l = wr && (sfr_addr_i == `CTT_ADDR_T2_LOW);
    wire wr_t2h = wr && (sfr_addr_i == `CTT_ADDR_T2_HIGH);
    wire wr_rl = wr && (sfr_addr_i == `CTT_ADDR_T2_RLD_LOW);
    wire wr_rh = wr && (sfr_addr_i == `CTT_ADDR_T2_RLD_HIGH);

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    wire timer0_run_bit = timer01_control_reg[`CTT_T01C_RUN0];     // R5
    wire timer1_run_bit = timer01_control_reg[`CTT_T01C_RUN1];
    wire timer0_pin_gating = timer01_mode_reg[`CTT_T01M_TIMER0_PIN_GATING];    // R5
    wire timer1_pin_gating = timer01_mode_reg[`CTT_T01M_GATE1];    // R5
    wire timer0_counter_select = timer01_mode_reg[`CTT_T01M_CSEL0];
    wire timer1_counter_select = timer01_mode_reg[`CTT_T01M_CSEL1];
    wire [1:0] t0_mode_bits = timer01_mode_reg[`CTT_T01M_MODE0_HI:`CTT_T01M_MODE0_LO];
    wire [1:0] t1_mode_bits = timer01_mode_reg[`CTT_T01M_MODE1_HI:`CTT_T01M_MODE1_LO];
    wire ctt_t01_mode_t t0_mode = ctt_t01_mode_t'(t0_mode_bits);
    wire ctt_t01_mode_t t1_mode = ctt_t01_mode_t'(t1_mode_bits);

    wire timer2_run_bit = timer2_control_reg[`CTT_T2C_RUN];
    wire timer2_counter_select = timer2_control_reg[`CTT_T2C_CSEL];
    wire timer2_capture_select = timer2_control_reg[`CTT_T2C_CAP_SEL];
    wire timer2_external_enable = timer2_control_reg[`CTT_T2C_EXT_EN];
    wire transmit_baud_select = timer2_control_reg[`CTT_T2C_TX_BAUD];
    wire receive_baud_select = timer2_control_reg[`CTT_T2C_RX_BAUD];

    // ----------------------------------------------------------------
    // timer 0/1 step
    // ----------------------------------------------------------------
    // low byte bits 7:5 are carried through untouched in 13-bit mode
    function automatic ctt_step_t t01_step(input ctt_t01_mode_t mode,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
        ctt_step_t r;
        logic [12:0] c13;
        logic [15:0] c16;
        r.ovf = 1'b0;
        r.hi = hi;
        r.lo = lo;
        c13 = {hi, lo[4:0]} + 13'h0001;
        c16 = {hi, lo} + 16'h0001;
        unique case (mode)
            T01_COUNT13: begin
                r.ovf = &{hi, lo[4:0]};                  // R2
                r.hi = c13[12:5];
                r.lo = {lo[7:5], c13[4:0]};              // R2
            end
            T01_COUNT16: begin
                r.ovf = &{hi, lo};                       // R7
                r.hi = c16[15:8];
                r.lo = c16[7:0];
            end
            T01_RELOAD8: begin
                r.ovf = &lo;
                r.lo = (&lo) ? hi : lo + 8'h01;          // R8
            end
            T01_SPLIT: begin
                r.ovf = &lo;                             // R10
                r.lo = lo + 8'h01;
            end
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // timer 0
    // ----------------------------------------------------------------
    wire t0_split = (t0_mode == T01_SPLIT);
    wire t0_event = timer0_counter_select ? t0_pin_fall : 1'b1;    // R1
    wire t0_tick = timer0_run_bit & (~timer0_pin_gating | int_a_level)
                   & t0_event;                                      // R4
    wire ctt_step_t s0 = t01_step(t0_mode, timer0_count_low, timer0_count_high);
    wire th0_tick = t0_split & timer1_run_bit;                      // R11
    wire th0_ovf = th0_tick & (&timer0_count_high);

    wire [7:0] next_t0_low = wr_t0l ? sfr_wdata_i :
                             (t0_tick ? s0.lo : timer0_count_low);
    wire [7:0] next_t0_high = wr_t0h ? sfr_wdata_i :
                              (th0_tick ? timer0_count_high + 8'h01 :
                               (t0_tick ? s0.hi : timer0_count_high));

    // ----------------------------------------------------------------
    // timer 1
    // ----------------------------------------------------------------
    // with timer 0 split, its run bit belongs to timer 0 high byte, so
    // timer 1 is started and stopped by leaving or entering mode 3 and by its gate with pin b
    wire t1_run = t0_split ? 1'b1 : timer1_run_bit;                // R12
    wire t1_event = timer1_counter_select ? t1_pin_fall : 1'b1;
    wire t1_tick = t1_run & (~timer1_pin_gating | int_b_level) & t1_event
                   & (t1_mode != T01_SPLIT);                        // R9
    wire ctt_step_t s1 = t01_step(t1_mode, timer1_count_low, timer1_count_high);
    wire t1_ovf = t1_tick & s1.ovf;

    wire [7:0] next_t1_low = wr_t1l ? sfr_wdata_i :
                             (t1_tick ? s1.lo : timer1_count_low);
    wire [7:0] next_t1_high = wr_t1h ? sfr_wdata_i :
                              (t1_tick ? s1.hi : timer1_count_high);

    // ----------------------------------------------------------------
    // timer 0/1 control register
    // ----------------------------------------------------------------
    wire tf0_set = t0_tick & s0.ovf;                                // R3
    wire tf1_set = t0_split ? th0_ovf : t1_ovf;                     // R11
    // a write only stores bits; run bit changes never touch the counts
    wire [7:0] t01c_base = wr_t01c ? sfr_wdata_i : timer01_control_reg;  // R6
    // hardware set beats a software clear in the same cycle
    wire [7:0] next_t01_ctrl = t01c_base
                               | ({7'h00, tf1_set} << `CTT_T01C_OVF1)
                               | ({7'h00, tf0_set} << `CTT_T01C_OVF0);
    wire [7:0] next_t01_mode = wr_t01m ? sfr_wdata_i : timer01_mode_reg;

    // ----------------------------------------------------------------
    // timer 2
    // ----------------------------------------------------------------
    wire t2_baud = transmit_baud_select | receive_baud_select;
    wire ctt_t2_mode_t t2_mode = ~timer2_run_bit ? T2_OFF :
                                 (t2_baud ? T2_BAUD :
                                  (timer2_capture_select ? T2_CAPTURE : T2_RELOAD));  // R13
    wire t2_event = timer2_counter_select ? t2_pin_fall : 1'b1;    // R20
    wire t2_tick = (t2_mode != T2_OFF) & t2_event;
    wire t2_roll = t2_tick & (&{timer2_count_high, timer2_count_low});
    // baud mode ignores the capture select and reloads on rollover
    wire t2_reload_on_roll = (t2_mode != T2_CAPTURE);               // R21
    wire t2_trig = timer2_external_enable & t2_trig_fall;
    wire t2_trig_reload = t2_trig & (t2_mode == T2_RELOAD);         // R15
    wire t2_capture = t2_trig & (t2_mode == T2_CAPTURE);            // R17
    wire [15:0] t2_count = {timer2_count_high, timer2_count_low};
    wire [15:0] t2_reload = {timer2_reload_high, timer2_reload_low};
    wire [15:0] t2_inc = t2_count + 16'h0001;

    logic [15:0] t2_stepped;
    always_comb begin
        if (t2_trig_reload || (t2_roll && t2_reload_on_roll)) begin
            t2_stepped = t2_reload;                      // R14
        end else if (t2_tick) begin
            t2_stepped = t2_inc;                         // R16
        end else begin
            t2_stepped = t2_count;
        end
    end

    wire [7:0] next_t2_low = wr_t2l ? sfr_wdata_i : t2_stepped[7:0];
    wire [7:0] next_t2_high = wr_t2h ? sfr_wdata_i : t2_stepped[15:8];
    // a capture edge wins over a software write of the same register
    wire [7:0] next_rld_low = t2_capture ? timer2_count_low :
                              (wr_rl ? sfr_wdata_i : timer2_reload_low);   // R17
    wire [7:0] next_rld_high = t2_capture ? timer2_count_high :
                               (wr_rh ? sfr_wdata_i : timer2_reload_high);

    wire tf2_set = t2_roll & ~t2_baud;                              // R18
    wire timer2_external_flag_set = t2_trig;                                        // R19
    wire [7:0] t2c_base = wr_t2c ? sfr_wdata_i : timer2_control_reg;
    wire [7:0] next_t2_ctrl = t2c_base
                              | ({7'h00, tf2_set} << `CTT_T2C_OVF)       // R16
                              | ({7'h00, timer2_external_flag_set} << `CTT_T2C_EXT_FLAG); // R15

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire [7:0] next_rdata =
        (sfr_addr_i == `CTT_ADDR_T01_CTRL) ? timer01_control_reg :
        (sfr_addr_i == `CTT_ADDR_T01_MODE) ? timer01_mode_reg :
        (sfr_addr_i == `CTT_ADDR_T0_LOW) ? timer0_count_low :
        (sfr_addr_i == `CTT_ADDR_T1_LOW) ? timer1_count_low :
        (sfr_addr_i == `CTT_ADDR_T0_HIGH) ? timer0_count_high :
        (sfr_addr_i == `CTT_ADDR_T1_HIGH) ? timer1_count_high :
        (sfr_addr_i == `CTT_ADDR_T2_CTRL) ? timer2_control_reg :
        (sfr_addr_i == `CTT_ADDR_T2_RLD_LOW) ? timer2_reload_low :
        (sfr_addr_i == `CTT_ADDR_T2_RLD_HIGH) ? timer2_reload_high :
        (sfr_addr_i == `CTT_ADDR_T2_LOW) ? timer2_count_low :
        (sfr_addr_i == `CTT_ADDR_T2_HIGH) ? timer2_count_high :
        `CTT_RST_BYTE;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            timer01_control_reg <= `CTT_RST_BYTE;
            timer01_mode_reg <= `CTT_RST_BYTE;
            timer2_control_reg <= `CTT_RST_BYTE;
            timer0_count_low <= `CTT_RST_BYTE;
            timer0_count_high <= `CTT_RST_BYTE;
            timer1_count_low <= `CTT_RST_BYTE;
            timer1_count_high <= `CTT_RST_BYTE;
            timer2_count_low <= `CTT_RST_BYTE;
            timer2_count_high <= `CTT_RST_BYTE;
            timer2_reload_low <= `CTT_RST_BYTE;
            timer2_reload_high <= `CTT_RST_BYTE;
        end else if (ce_i) begin
            timer01_control_reg <= next_t01_ctrl;
            timer01_mode_reg <= next_t01_mode;
            timer2_control_reg <= next_t2_ctrl;
            timer0_count_low <= next_t0_low;
            timer0_count_high <= next_t0_high;
            timer1_count_low <= next_t1_low;
            timer1_count_high <= next_t1_high;
            timer2_count_low <= next_t2_low;
            timer2_count_high <= next_t2_high;
            timer2_reload_low <= next_rld_low;
            timer2_reload_high <= next_rld_high;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sfr_rdata_o <= `CTT_RST_BYTE;
            timer1_overflow_o <= 1'b0;
            timer2_overflow_o <= 1'b0;
        end else if (ce_i) begin
            sfr_rdata_o <= next_rdata;
            timer1_overflow_o <= t1_ovf;
            timer2_overflow_o <= t2_roll;
        end
    end

    assign timer0_irq_o = timer01_control_reg[`CTT_T01C_OVF0];
    assign timer1_irq_o = timer01_control_reg[`CTT_T01C_OVF1];
    assign timer2_irq_o = timer2_control_reg[`CTT_T2C_OVF]
                          | timer2_control_reg[`CTT_T2C_EXT_FLAG];

endmodule

// File: bench/ctt_timers_checker.sv
`timescale 1ns/100ps
module ctt_timers_checker (
    input wire logic mclk_i,                // core clock
    input wire logic sys_rst_i,             // async reset
    input wire logic ce_i,                  // clock enable
    input wire logic [7:0] sfr_addr_i,      // register address
    input wire logic sfr_wr_i,              // write strobe
    input wire logic [7:0] sfr_wdata_i,     // write data
    input wire logic ext_int_a_pin_i,       // timer 0 gate pin
    input wire logic timer2_trigger_pin_i,  // timer 2 trigger
    input wire logic timer1_overflow_o,     // timer 1 overflow pulse
    input wire logic timer2_overflow_o,     // timer 2 rollover pulse
    input wire logic timer0_irq_o,          // timer 0 flag
    input wire logic timer1_irq_o,          // timer 1 flag
    input wire logic timer2_irq_o           // timer 2 flags
);
    // ------------------------------------------------
    // shadows of bits only software can change
    // ------------------------------------------------
    logic [7:0] mode_sh;
    logic run0_sh;
    logic [5:0] t2_sh;
    wire wr_ctl = ce_i && sfr_wr_i && sfr_addr_i == 8'h88;
    wire wr_mode = ce_i && sfr_wr_i && sfr_addr_i == 8'h89;
    wire wr_t2 = ce_i && sfr_wr_i && sfr_addr_i == 8'hC8;
    wire baud = t2_sh[5] | t2_sh[4];
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_sh <= 8'h00;
            run0_sh <= 1'b0;
            t2_sh <= 6'h00;
        end else begin
            if (wr_mode) mode_sh <= sfr_wdata_i;
            if (wr_ctl) run0_sh <= sfr_wdata_i[4];
            if (wr_t2) t2_sh <= sfr_wdata_i[5:0];
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    ovf0_write_a: assert property (wr_ctl && sfr_wdata_i[5] |=> timer0_irq_o)
        else $error("flag 0 write lost");
    ovf1_write_a: assert property (wr_ctl && sfr_wdata_i[7] |=> timer1_irq_o)
        else $error("flag 1 write lost");
    t2_flag_write_a: assert property (wr_t2 && (|sfr_wdata_i[7:6]) |=> timer2_irq_o)
        else $error("flag 2 write lost");
    gate_hold_a: assert property ((!wr_ctl && (!run0_sh || mode_sh[3] && !ext_int_a_pin_i))[*4]
        ##0 !timer0_irq_o |=> !timer0_irq_o) else $error("timer 0 ran gated");
    t1_mode3_hold_a: assert property ((!wr_mode && !wr_ctl && mode_sh[5:4] == 2'b11
        && mode_sh[1:0] != 2'b11)[*2] ##0 !timer1_irq_o |=> !timer1_irq_o && !timer1_overflow_o)
        else $error("timer 1 moved in mode 3");
    t2_off_a: assert property ((!wr_t2 && !t2_sh[2] && !t2_sh[3])[*2] ##0 !timer2_irq_o
        |=> !timer2_irq_o && !timer2_overflow_o) else $error("timer 2 active while off");
    baud_no_ovf_a: assert property (!wr_t2 && baud && !t2_sh[3] && !timer2_irq_o
        |=> !timer2_irq_o) else $error("baud set timer 2 flag");
    baud_trigger_a: assert property (ce_i && baud && t2_sh[3] && !wr_t2 && !$past(sys_rst_i)
        && $fell(timer2_trigger_pin_i) |-> ##[1:4] timer2_irq_o)
        else $error("baud trigger flag lost");
endmodule

bind ctt_timers ctt_timers_checker u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .ext_int_a_pin_i(ext_int_a_pin_i), .timer2_trigger_pin_i(timer2_trigger_pin_i),
    .timer1_overflow_o(timer1_overflow_o), .timer2_overflow_o(timer2_overflow_o),
    .timer0_irq_o(timer0_irq_o), .timer1_irq_o(timer1_irq_o), .timer2_irq_o(timer2_irq_o));

// File: bench/ctt_pin_partner.sv
`timescale 1ns/100ps
module ctt_pin_partner (
    input wire logic mclk_i,     // core clock
    input wire logic trig_go_i,  // start one trigger low pulse
    input wire logic cnt_go_i,   // start one count low pulse
    output logic trigger_o,      // trigger pin, idles high
    output logic count_o         // count pin, idles high
);
    // low for two cycles so the synchroniser surely sees both levels
    logic [1:0] trig_left = 2'h0;
    logic [1:0] cnt_left = 2'h0;
    always_ff @(posedge mclk_i) begin
        trig_left <= trig_go_i ? 2'h2 : trig_left - {1'b0, trig_left != 2'h0};
        cnt_left <= cnt_go_i ? 2'h2 : cnt_left - {1'b0, cnt_left != 2'h0};
    end
    assign trigger_o = trig_left == 2'h0;
    assign count_o = cnt_left == 2'h0;
endmodule

// File: bench/classic_three_timer_unit_test.sv
`timescale 1ns/100ps
module classic_three_timer_unit_test;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr_en = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic gate_a = 1'b0;
    logic trig_go = 1'b0;
    logic cnt_go = 1'b0;
    logic trig_pin, cnt_pin, ovf1, ovf2, irq0, irq1, irq2;
    logic [7:0] rdata;
    logic [7:0] regs [12] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hC8, 8'hCA,
        8'hCB, 8'hCC, 8'hCD, 8'h8F};
    int errors = 0;
    int tests_run = 0;
    `define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
    always #25 mclk_i = ~mclk_i;
    ctt_timers dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .sfr_addr_i(addr),
        .sfr_wr_i(wr_en), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .ext_int_a_pin_i(gate_a),
        .ext_int_b_pin_i(1'b0), .timer0_count_pin_i(1'b1), .timer1_count_pin_i(1'b1),
        .timer2_count_pin_i(cnt_pin), .timer2_trigger_pin_i(trig_pin),
        .timer1_overflow_o(ovf1), .timer2_overflow_o(ovf2), .timer0_irq_o(irq0),
        .timer1_irq_o(irq1), .timer2_irq_o(irq2));
    ctt_pin_partner far (.mclk_i(mclk_i), .trig_go_i(trig_go), .cnt_go_i(cnt_go),
        .trigger_o(trig_pin), .count_o(cnt_pin));
    // ------------------------------------------------
    // access tasks
    // ------------------------------------------------
    task automatic idle(input int n);
        wr_en = 1'b0;
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(posedge mclk_i);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        idle(1);
        `CHK(rdata, e)
    endtask
    // counts exactly k enabled cycles, the stop write lands on the last one
    task automatic t01(input logic [7:0] md, tl, th, rb, input int k);
        wr(8'h89, md);
        wr(8'h8A, tl);
        wr(8'h8C, th);
        wr(8'h88, rb);
        idle(k - 1);
        wr(8'h88, 8'h00);
    endtask
    task automatic fire(input logic trig);
        trig_go = trig;
        cnt_go = !trig;
        idle(1);
        trig_go = 1'b0;
        cnt_go = 1'b0;
        idle(6);
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        idle(5);
        sys_rst_i = 1'b0;
        foreach (regs[i]) rd(regs[i], 8'h00);
        done("reset");
        t01(8'h01, 8'hFD, 8'hFF, 8'h10, 3);
        rd(8'h8A, 8'h00);
        rd(8'h88, 8'h20);
        `CHK(irq0, 1'b1)
        t01(8'h00, 8'hFE, 8'hFF, 8'h30, 2);
        rd(8'h8A, 8'hE0);
        rd(8'h8C, 8'h00);
        t01(8'h02, 8'hFD, 8'h55, 8'h10, 3);
        rd(8'h8A, 8'h55);
        rd(8'h8C, 8'h55);
        done("timer0 modes");
        t01(8'h39, 8'h00, 8'h00, 8'h50, 4);
        rd(8'h8A, 8'h00);
        gate_a = 1'b1;
        t01(8'h39, 8'h00, 8'h00, 8'h50, 4);
        rd(8'h8A, 8'h04);
        done("gating");
        wr(8'h8B, 8'h10);
        t01(8'h33, 8'h00, 8'hFE, 8'hD0, 2);
        rd(8'h8A, 8'h02);
        rd(8'h8C, 8'h00);
        rd(8'h88, 8'h80);
        rd(8'h8B, 8'h10);
        wr(8'h89, 8'h03);
        idle(1);
        wr(8'h89, 8'h33);
        rd(8'h8B, 8'h12);
        done("split mode");
        wr(8'hCA, 8'h34);
        wr(8'hCB, 8'h12);
        wr(8'hCC, 8'hFD);
        wr(8'hCD, 8'hFF);
        wr(8'hC8, 8'hC4);
        idle(2);
        wr(8'hC8, 8'h00);
        rd(8'hCC, 8'h34);
        rd(8'hCD, 8'h12);
        rd(8'hC8, 8'h80);
        done("reload");
        wr(8'hCC, 8'h10);
        wr(8'hCD, 8'h20);
        wr(8'hC8, 8'h0F);
        fire(1'b1);
        rd(8'hCA, 8'h10);
        rd(8'hCB, 8'h20);
        rd(8'hC8, 8'h4F);
        fire(1'b0);
        fire(1'b0);
        rd(8'hCC, 8'h12);
        wr(8'hC8, 8'h0E);
        fire(1'b1);
        rd(8'hCC, 8'h10);
        done("capture");
        wr(8'hCC, 8'hFE);
        wr(8'hCD, 8'hFF);
        wr(8'hC8, 8'h15);
        idle(2);
        wr(8'hC8, 8'h1D);
        fire(1'b1);
        rd(8'hC8, 8'h5D);
        rd(8'hCA, 8'h10);
        rd(8'hCD, 8'h20);
        wr(8'hC8, 8'h00);
        done("baud");
        wrap_up();
    end
    initial begin
        repeat (4000) @(posedge mclk_i);
        errors++;
        wrap_up();
    end
endmodule
